// >>> shared/sgcf_defs.svh
// constants for the serial gated clock fan-out
`ifndef SGCF_DEFS_SVH
`define SGCF_DEFS_SVH
`define SGCF_NUM_OUT 10
`define SGCF_DEV_ADDR 7'h69
`define SGCF_NUM_BYTES 3
`define SGCF_GATE_RESET 8'hFF
`define SGCF_LOW_LSB 0
`define SGCF_MID_LSB 4
`define SGCF_HIGH_LSB 6
`define SGCF_SYNC_STAGES 2
`define SGCF_SYNC_RESET 4'h3
`endif

// >>> shared/sgcf_pkg.sv
// types for the serial gated clock fan-out
package sgcf_pkg;
    typedef enum logic [2:0] {
        SGCF_IDLE = 3'b000,
        SGCF_ADDR = 3'b001,
        SGCF_AACK = 3'b010,
        SGCF_DATA = 3'b011,
        SGCF_DACK = 3'b100,
        SGCF_SKIP = 3'b101
    } sgcf_state_t;
endpackage

// >>> shared/sgcf_sync_if.sv
// interface carrying raw pins into the synchroniser and clean levels back
`timescale 1ns/1ps
`default_nettype none
interface sgcf_sync_if;
    logic [3:0] raw;
    logic [3:0] clean;
    modport sync (input raw, output clean);
    modport user (output raw, input clean);
endinterface
`default_nettype wire

// >>> design/sgcf_sync.sv
// two-flop synchroniser for the asynchronous pins
`timescale 1ns/1ps
`default_nettype none
`include "sgcf_defs.svh"
module sgcf_sync
    import sgcf_pkg::*;
#(
    parameter int WIDTH = 4,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    // pins
    sgcf_sync_if.sync pins
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            meta <= RST_VAL;
            stable <= RST_VAL;
        end else if (clk_en) begin
            meta <= pins.raw;
            stable <= meta;
        end
    end
    assign pins.clean = stable;
endmodule
`default_nettype wire

// >>> design/sgcf_top.sv
// serial gated clock fan-out: two-wire write slave and gated clock outputs
//
// Functional notes
// - each of ten outputs repeats the reference clock when enabled.
// - global enable low puts every output in high impedance.
// - one configuration bit per output enables or disables it.
// - after power-up every output is enabled.
// - bytes go in order from byte 0; bits msb first.
// - slave answers address 1101001, msb first, then read/write bit 0 (write); a read is not acknowledged.
// - byte 0 bits 3..0 gate outputs 3..0.
// - byte 1 bits 7..4 gate outputs 7..4.
// - byte 2 bit 7 gates output 9, bit 6 output 8.
// - all gating bits reset to active.
`timescale 1ns/1ps
`default_nettype none
`include "sgcf_defs.svh"
module sgcf_top
    import sgcf_pkg::*;
#(
    parameter int NUM_OUT = `SGCF_NUM_OUT
) (
    // clock, reset, enable
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    // reference clock and global enable pins
    input wire logic ref_clk_pin,
    input wire logic out_enable_pin,
    // serial pins; data is open drain for acknowledge
    input wire logic serial_clk_pin,
    input wire logic serial_data_pin_in,
    output logic serial_data_pin_out,
    output logic serial_data_pin_oe,
    // buffered clock outputs, three-state as level plus enable
    output logic [NUM_OUT-1:0] clk_out,
    output logic [NUM_OUT-1:0] clk_out_oe
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    sgcf_sync_if pins ();
    assign pins.raw = {out_enable_pin, ref_clk_pin, serial_data_pin_in, serial_clk_pin};
    // serial pins idle high, so their stages reset high: no false edge after reset
    sgcf_sync #(.WIDTH(4), .RST_VAL(`SGCF_SYNC_RESET)) u_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .pins(pins)
    );
    wire logic scl_s = pins.clean[0];
    wire logic sda_s = pins.clean[1];
    wire logic ref_s = pins.clean[2];
    wire logic oe_s = pins.clean[3];

    // ------------------------------------------------------------
    // edge and condition detection
    // ------------------------------------------------------------
    logic scl_d;
    logic sda_d;
    logic ref_d;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
            ref_d <= 1'b0;
        end else if (clk_en) begin
            scl_d <= scl_s;
            sda_d <= sda_s;
            ref_d <= ref_s;
        end
    end
    wire logic scl_rise = scl_s & ~scl_d;
    wire logic scl_fall = ~scl_s & scl_d;
    wire logic start_cond = scl_s & scl_d & sda_d & ~sda_s;
    wire logic stop_cond = scl_s & scl_d & ~sda_d & sda_s;
    // a low reference level is the only safe window for gate changes
    wire logic ref_low = ~ref_s & ~ref_d;

    // ------------------------------------------------------------
    // serial write slave
    // ------------------------------------------------------------
    sgcf_state_t state;
    sgcf_state_t next_state;
    logic [7:0] shift;
    logic [2:0] bit_cnt;
    logic [1:0] byte_idx;
    logic ack_drive;
    logic [7:0] gate_low;
    logic [7:0] gate_mid;
    logic [7:0] gate_high;

    wire logic [7:0] shift_next = {shift[6:0], sda_s};
    wire logic last_bit = (bit_cnt == 3'd7);
    wire logic addr_hit = (shift_next[7:1] == `SGCF_DEV_ADDR) & ~shift_next[0];
    wire logic byte_done = scl_rise & last_bit;
    wire logic store_byte = (state == SGCF_DATA) & byte_done;

    always_comb begin
        next_state = state;
        unique case (state)
            SGCF_IDLE: next_state = SGCF_IDLE;
            SGCF_ADDR: begin
                if (byte_done) begin
                    next_state = addr_hit ? SGCF_AACK : SGCF_SKIP;
                end
            end
            SGCF_AACK: begin
                if (scl_fall & ack_drive) begin
                    next_state = SGCF_DATA;
                end
            end
            SGCF_DATA: begin
                if (byte_done) begin
                    next_state = SGCF_DACK;
                end
            end
            SGCF_DACK: begin
                if (scl_fall & ack_drive) begin
                    next_state = SGCF_DATA;
                end
            end
            SGCF_SKIP: next_state = SGCF_SKIP;
            default: next_state = SGCF_IDLE;
        endcase
        if (start_cond) begin
            next_state = SGCF_ADDR;
        end else if (stop_cond) begin
            next_state = SGCF_IDLE;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= SGCF_IDLE;
        end else if (clk_en) begin
            state <= next_state;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            shift <= 8'h00;
            bit_cnt <= 3'd0;
        end else if (clk_en) begin
            if (start_cond || state == SGCF_AACK || state == SGCF_DACK) begin
                bit_cnt <= 3'd0;
            end else if (scl_rise) begin
                shift <= shift_next;
                bit_cnt <= bit_cnt + 3'd1;
            end
        end
    end

    // acknowledge: pull data low from the falling edge after the eighth bit
    // through the ninth clock pulse; released on the falling edge after it
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ack_drive <= 1'b0;
        end else if (clk_en) begin
            if (start_cond || stop_cond) begin
                ack_drive <= 1'b0;
            end else if ((state == SGCF_AACK || state == SGCF_DACK) && scl_fall) begin
                ack_drive <= ~ack_drive;
            end
        end
    end

    // byte index ascends from byte 0 per transfer
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            byte_idx <= 2'd0;
        end else if (clk_en) begin
            if (start_cond) begin
                byte_idx <= 2'd0;
            end else if (store_byte && byte_idx != 2'd3) begin
                byte_idx <= byte_idx + 2'd1;
            end
        end
    end

    // ------------------------------------------------------------
    // configuration bytes
    // ------------------------------------------------------------
    // commit whole byte only
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            gate_low <= `SGCF_GATE_RESET;
            gate_mid <= `SGCF_GATE_RESET;
            gate_high <= `SGCF_GATE_RESET;
        end else if (clk_en && store_byte) begin
            // bytes past the third are accepted and dropped
            unique case (byte_idx)
                2'd0: gate_low <= shift_next;
                2'd1: gate_mid <= shift_next;
                2'd2: gate_high <= shift_next;
                2'd3: gate_low <= gate_low;
            endcase
        end
    end

    wire logic [3:0] gate_grp_low = gate_low[`SGCF_LOW_LSB +: 4];
    wire logic [3:0] gate_grp_mid = gate_mid[`SGCF_MID_LSB +: 4];
    wire logic [1:0] gate_grp_high = gate_high[`SGCF_HIGH_LSB +: 2];
    wire logic [9:0] gate_map = {gate_grp_high, gate_grp_mid, gate_grp_low};

    // ------------------------------------------------------------
    // gated outputs
    // ------------------------------------------------------------
    logic [NUM_OUT-1:0] gate_live;
    // gate changes only while reference low
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            gate_live <= '1;
        end else if (clk_en && ref_low) begin
            gate_live <= gate_map[NUM_OUT-1:0];
        end
    end

    // global enable drives three-state
    // outputs lag the pin by the synchroniser depth plus the output register; frequency is kept
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            clk_out <= '0;
            clk_out_oe <= '0;
            serial_data_pin_out <= 1'b0;
            serial_data_pin_oe <= 1'b0;
        end else if (clk_en) begin
            clk_out <= {NUM_OUT{ref_s}} & gate_live;
            clk_out_oe <= {NUM_OUT{oe_s}};
            serial_data_pin_out <= 1'b0;
            serial_data_pin_oe <= ack_drive;
        end
    end
endmodule
`default_nettype wire

// >>> tb/sgcf_top_properties.sv
// pin-level assertions for the clock fan-out
`timescale 1ns/1ps
`default_nettype none
module sgcf_props #(
    parameter int NUM_OUT = 10
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    // pins
    input wire logic ref_clk_pin,
    input wire logic out_enable_pin,
    input wire logic serial_clk_pin,
    input wire logic serial_data_pin_in,
    // driven outputs
    input wire logic serial_data_pin_out,
    input wire logic serial_data_pin_oe,
    input wire logic [NUM_OUT-1:0] clk_out,
    input wire logic [NUM_OUT-1:0] clk_out_oe
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    property p_oe_same; clk_out_oe == {NUM_OUT{clk_out_oe[0]}}; endproperty
    property p_oe_off; !out_enable_pin [*8] |-> clk_out_oe == '0; endproperty
    property p_oe_on; out_enable_pin [*8] |-> &clk_out_oe; endproperty
    // edges trail the pin by two sync stages plus the output register
    // a gated output drops only while the reference is low
    property p_rise; (clk_out & ~$past(clk_out)) != '0 |-> $past(ref_clk_pin, 3); endproperty
    property p_fall; (~clk_out & $past(clk_out)) != '0 |-> !$past(ref_clk_pin, 3); endproperty
    property p_ack_rise; $rose(serial_data_pin_oe) |-> !serial_clk_pin; endproperty
    property p_ack_hold;
        serial_data_pin_oe && $rose(serial_clk_pin) |-> serial_data_pin_oe [*8];
    endproperty
    property p_od_low; serial_data_pin_oe |-> !serial_data_pin_out; endproperty
    a_oe_same: assert property (p_oe_same) else $error("enables differ");
    a_oe_off: assert property (p_oe_off) else $error("not high-z");
    a_oe_on: assert property (p_oe_on) else $error("not driven");
    a_rise: assert property (p_rise) else $error("rise off ref");
    a_fall: assert property (p_fall) else $error("fall off ref");
    a_ack_rise: assert property (p_ack_rise) else $error("ack early");
    a_ack_hold: assert property (p_ack_hold) else $error("ack short");
    a_od_low: assert property (p_od_low) else $error("data not low");
    cover property ($rose(serial_data_pin_oe));
    cover property (clk_out_oe == '0);
    cover property ((~clk_out & $past(clk_out)) != '0);
endmodule
bind sgcf_top sgcf_props #(.NUM_OUT(NUM_OUT)) u_props (
    .clk(clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .ref_clk_pin(ref_clk_pin),
    .out_enable_pin(out_enable_pin),
    .serial_clk_pin(serial_clk_pin),
    .serial_data_pin_in(serial_data_pin_in),
    .serial_data_pin_out(serial_data_pin_out),
    .serial_data_pin_oe(serial_data_pin_oe),
    .clk_out(clk_out),
    .clk_out_oe(clk_out_oe)
);
`default_nettype wire

// >>> tb/sgcf_host.sv
// host model: two-wire write master, data line pulled up
`timescale 1ns/1ps
`default_nettype none
module sgcf_host (
    // clock and wire level
    input wire logic clk,
    input wire logic sda_line,
    // driven pins
    output logic scl,
    output logic sda
);
    int acks = 0;
    initial scl = 1'b1;
    initial sda = 1'b1;
    task automatic q();
        repeat (8) @(posedge clk);
    endtask
    // data moves mid-low so no false start is seen
    task automatic slot(input logic v);
        q();
        sda <= v;
        q();
        scl <= 1'b1;
        q();
        @(negedge clk);
        acks += int'(v && !sda_line);
        q();
        scl <= 1'b0;
    endtask
    task automatic start();
        q();
        sda <= 1'b0;
        q();
        scl <= 1'b0;
    endtask
    task automatic put(input logic [7:0] b, input int n);
        for (int i = 7; i > 7 - n; i--) slot(b[i]);
        if (n == 8) slot(1'b1);
    endtask
    task automatic stop();
        q();
        sda <= 1'b0;
        q();
        scl <= 1'b1;
        q();
        sda <= 1'b1;
        q();
    endtask
endmodule
`default_nettype wire

// >>> tb/test_sgcf_top.sv
// bench for the serial gated clock fan-out
`timescale 1ns/1ps
`default_nettype none
module test_sgcf_top;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic ref_clk_pin = 1'b0;
    logic out_enable_pin = 1'b1;
    logic scl, sda, sda_oe, sda_out;
    logic [9:0] clk_out, clk_out_oe, hi, lo;
    // open drain: the device can only pull the line low
    wire logic sda_line = sda & (~sda_oe | sda_out);
    int bad_count = 0;
    int compares = 0;
    int a0;
    always #2.5 clk = ~clk;
    always #40 ref_clk_pin <= ~ref_clk_pin;
    sgcf_top u_dut (.clk, .sys_rst, .clk_en(1'b1), .ref_clk_pin, .out_enable_pin,
        .serial_clk_pin(scl), .serial_data_pin_in(sda_line), .serial_data_pin_out(sda_out),
        .serial_data_pin_oe(sda_oe), .clk_out, .clk_out_oe);
    sgcf_host u_host (.clk, .sda_line, .scl, .sda);
    task automatic chk(input string n, input logic [9:0] e, input logic [9:0] s);
        compares++;
        if (s !== e) begin
            bad_count++;
            $display("[ERR] %s exp %h got %h", n, e, s);
        end
    endtask
    // one frame, last byte may be cut short, then watch the outputs
    task automatic wr(input logic [7:0] a, input logic [23:0] d, input int nb, input int n);
        a0 = u_host.acks;
        u_host.start();
        u_host.put(a, 8);
        for (int k = 0; k < nb; k++) u_host.put(d[23-8*k -: 8], k == nb - 1 ? n : 8);
        u_host.stop();
        hi = '0;
        lo = '0;
        repeat (48) begin
            @(negedge clk);
            hi |= clk_out;
            lo |= ~clk_out;
        end
    endtask
    task automatic t_power();
        wr(8'hD3, 24'h00_0000, 0, 8);
        chk("ack", 10'h000, 10'(u_host.acks - a0));
        chk("run", 10'h3FF, hi);
        chk("low", 10'h3FF, lo);
        $display("power done");
    endtask
    task automatic t_gate();
        wr(8'hD2, 24'h05_5080, 3, 8);
        chk("ack", 10'h004, 10'(u_host.acks - a0));
        chk("gate", 10'h255, hi);
        chk("low", 10'h3FF, lo);
        wr(8'hD2, 24'hF0_F0C0, 1, 4);
        chk("part", 10'h255, hi);
        wr(8'hD0, 24'h0F_F0C0, 3, 8);
        chk("addr", 10'h255, hi);
        $display("gate done");
    endtask
    task automatic t_enable();
        wr(8'hD2, 24'h0F_F0C0, 3, 8);
        chk("all", 10'h3FF, hi);
        @(posedge clk);
        out_enable_pin <= 1'b0;
        repeat (10) @(negedge clk);
        chk("hiz", 10'h000, clk_out_oe);
        @(posedge clk);
        out_enable_pin <= 1'b1;
        repeat (10) @(negedge clk);
        chk("drv", 10'h3FF, clk_out_oe);
        $display("enable done");
    endtask
    // all gates off, then a mid-run reset must bring every output back
    task automatic t_reset();
        wr(8'hD2, 24'h00_0000, 3, 8);
        chk("off", 10'h000, hi);
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        wr(8'hD3, 24'h00_0000, 0, 8);
        chk("rst", 10'h3FF, hi);
        $display("reset done");
    endtask
    task automatic end_sim();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        t_power();
        t_gate();
        t_enable();
        t_reset();
        end_sim();
    end
    initial begin
        #100000;
        bad_count++;
        $display("[ERR] watchdog exp finish got timeout");
        end_sim();
    end
endmodule
`default_nettype wire
